// ### rtl/tcc_capture_compare.sv
// Input capture and three-channel output compare unit of a 16-bit timer
module tcc_capture_compare #(
  parameter bit FIRST_INSTANCE = 1'b1
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Counter interface
  input  wire logic                  timer_tick,
  input  wire logic [15:0]           counter_value,
  input  wire logic                  counter_down,
  input  wire logic                  counter_write,
  input  wire logic [3:0]            waveform_mode_sel,
  output logic [15:0]                ceiling_value,
  output logic                       ceiling_match,
  // Capture trigger and control
  input  wire logic                  capture_input_pin,
  input  wire logic                  comparator_output,
  input  wire logic                  comparator_capture_select,
  input  wire logic                  capture_noise_cancel_en,
  input  wire logic                  capture_edge_rising,
  input  wire logic                  capture_irq_enable,
  input  wire logic                  capture_flag_clear,
  input  wire logic                  capture_irq_ack,
  output logic [15:0]                capture_value_reg,
  output logic                       capture_flag,
  output logic                       capture_irq,
  // CPU byte access
  input  wire tcc_pkg::tcc_cpu_req_t cpu_req,
  output logic [7:0]                 cpu_rdata,
  // Compare channels
  input  wire tcc_pkg::tcc_ch_ctrl_t ch_ctrl [tcc_pkg::CH_NUM],
  output tcc_pkg::tcc_ch_stat_t      ch_stat [tcc_pkg::CH_NUM]
);

  function automatic logic is_pwm(input logic [3:0] m);
    return !(m == tcc_pkg::WGM_NORMAL || m == tcc_pkg::WGM_CTC_CMP
             || m == tcc_pkg::WGM_CTC_CAP || m == tcc_pkg::WGM_RESERVED);
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    return m == tcc_pkg::WGM_PFC_CAP || m == tcc_pkg::WGM_PC_CAP
           || m == tcc_pkg::WGM_CTC_CAP || m == tcc_pkg::WGM_FAST_CAP;
  endfunction

  function automatic logic is_fast(input logic [3:0] m);
    return m == tcc_pkg::WGM_FAST8 || m == tcc_pkg::WGM_FAST9 || m == tcc_pkg::WGM_FAST10
           || m == tcc_pkg::WGM_FAST_CAP || m == tcc_pkg::WGM_FAST_CMP;
  endfunction

  function automatic logic [1:0] sel_chan(input tcc_pkg::tcc_sel_t s);
    return s[2:1];
  endfunction

  logic [15:0] icr_reg;
  logic [15:0] icr_next;
  logic        cflag_reg;
  logic        cflag_next;
  logic [7:0]  temp_reg;
  logic [7:0]  temp_next;
  logic        block_reg;
  logic        block_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [15:0] ocr_live   [tcc_pkg::CH_NUM];
  logic [15:0] ocr_buf    [tcc_pkg::CH_NUM];
  logic [15:0] ocr_view   [tcc_pkg::CH_NUM];
  logic        pwm;
  logic        fast;
  logic        load_point;
  logic        raw_trigger;
  logic        detect_en;
  logic        cap_event;
  logic        cap_take;

  assign pwm  = is_pwm(waveform_mode_sel);
  assign fast = is_fast(waveform_mode_sel);

  // Ceiling source per mode
  always_comb begin
    unique case (waveform_mode_sel)
      tcc_pkg::WGM_PC8,  tcc_pkg::WGM_FAST8:  ceiling_value = tcc_pkg::TOP_8BIT;
      tcc_pkg::WGM_PC9,  tcc_pkg::WGM_FAST9:  ceiling_value = tcc_pkg::TOP_9BIT;
      tcc_pkg::WGM_PC10, tcc_pkg::WGM_FAST10: ceiling_value = tcc_pkg::TOP_10BIT;
      tcc_pkg::WGM_CTC_CMP, tcc_pkg::WGM_PFC_CMP,
      tcc_pkg::WGM_PC_CMP,  tcc_pkg::WGM_FAST_CMP: ceiling_value = ocr_live[0];
      tcc_pkg::WGM_PFC_CAP, tcc_pkg::WGM_PC_CAP,
      tcc_pkg::WGM_CTC_CAP, tcc_pkg::WGM_FAST_CAP: ceiling_value = icr_reg;
      default:                                     ceiling_value = tcc_pkg::CNT_MAX;
    endcase
  end

  // A blocked tick misses the ceiling, so the counter runs on to the maximum
  assign ceiling_match = timer_tick && !block_reg
                         && (counter_value == ceiling_value);

  // Phase and frequency correct modes load at the floor, all other PWM modes at the ceiling
  assign load_point = pwm && ((waveform_mode_sel == tcc_pkg::WGM_PFC_CAP
                               || waveform_mode_sel == tcc_pkg::WGM_PFC_CMP)
                              ? (timer_tick && counter_value == tcc_pkg::CNT_BOTTOM)
                              : ceiling_match);

  // Software may raise a capture through the pin's own port drive
  assign raw_trigger = (FIRST_INSTANCE && comparator_capture_select)
                       ? comparator_output : capture_input_pin;
  assign detect_en   = !cap_is_top(waveform_mode_sel);

  tcc_capture_filter u_filter (
    .clk         (clk),
    .rst         (rst),
    .raw_in      (raw_trigger),
    .cancel_en   (capture_noise_cancel_en),
    .detect_en   (detect_en),
    .edge_rising (capture_edge_rising),
    .cap_event   (cap_event)
  );

  assign cap_take = cap_event;

  always_comb begin
    icr_next   = icr_reg;
    cflag_next = cflag_reg;
    temp_next  = temp_reg;
    block_next = block_reg;
    rdata_next = rdata_reg;
    if (cap_take) begin
      icr_next = counter_value;
    end else if (cpu_req.wr && cpu_req.sel == tcc_pkg::SEL_CAP_LO
                 && cap_is_top(waveform_mode_sel)) begin
      icr_next = {temp_reg, cpu_req.wdata};
    end
    if (capture_flag_clear || capture_irq_ack) begin
      cflag_next = 1'b0;
    end
    if (cap_take) begin
      cflag_next = 1'b1;
    end
    if (timer_tick) begin
      block_next = 1'b0;
    end
    if (counter_write) begin
      block_next = 1'b1;
    end
    if (cpu_req.wr && cpu_req.sel[0]) begin
      temp_next = cpu_req.wdata;
    end
    if (cpu_req.rd) begin
      if (sel_chan(cpu_req.sel) == tcc_pkg::SEL_CHAN_CAP) begin
        if (cpu_req.sel[0]) begin
          rdata_next = temp_reg;
        end else begin
          rdata_next = icr_reg[7:0];
          temp_next  = icr_reg[15:8];
        end
      end else if (cpu_req.sel[0]) begin
        rdata_next = ocr_view[sel_chan(cpu_req.sel)][15:8];
      end else begin
        rdata_next = ocr_view[sel_chan(cpu_req.sel)][7:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      icr_reg   <= tcc_pkg::RST_WORD;
      cflag_reg <= tcc_pkg::RST_BIT;
      temp_reg  <= tcc_pkg::RST_BYTE;
      block_reg <= tcc_pkg::RST_BIT;
      rdata_reg <= tcc_pkg::RST_BYTE;
    end else begin
      icr_reg   <= icr_next;
      cflag_reg <= cflag_next;
      temp_reg  <= temp_next;
      block_reg <= block_next;
      rdata_reg <= rdata_next;
    end
  end

  assign capture_value_reg = icr_reg;
  assign capture_flag      = cflag_reg;
  assign capture_irq       = cflag_reg && capture_irq_enable;
  assign cpu_rdata         = rdata_reg;

  for (genvar i = 0; i < tcc_pkg::CH_NUM; i++) begin : g_ch
    logic [15:0]       live_next;
    logic [15:0]       buf_next;
    logic              flag_reg;
    logic              flag_next;
    logic              out_reg;
    logic              out_next;
    logic              wr_lo;
    logic              match_ok;
    logic              level;
    tcc_pkg::tcc_act_t act;

    assign wr_lo    = cpu_req.wr && !cpu_req.sel[0] && sel_chan(cpu_req.sel) == 2'(i);
    assign match_ok = timer_tick && !block_reg
                      && (counter_value == ocr_live[i]);
    assign act      = ch_ctrl[i].action;
    assign ocr_view[i] = pwm ? ocr_buf[i] : ocr_live[i];

    always_comb begin
      live_next = ocr_live[i];
      buf_next  = ocr_buf[i];
      flag_next = flag_reg;
      out_next  = out_reg;
      level     = fast ? 1'b0 : counter_down;
      if (wr_lo && pwm) begin
        buf_next = {temp_reg, cpu_req.wdata};
      end else if (wr_lo) begin
        live_next = {temp_reg, cpu_req.wdata};
        buf_next  = {temp_reg, cpu_req.wdata};
      end
      if (load_point) begin
        live_next = ocr_buf[i];
      end
      if (ch_ctrl[i].flag_clear || ch_ctrl[i].irq_ack) begin
        flag_next = 1'b0;
      end
      if (match_ok) begin
        flag_next = 1'b1;
      end
      if (!pwm && (match_ok || ch_ctrl[i].force_strobe)) begin
        unique case (act)
          tcc_pkg::ACT_NONE:   out_next = out_reg;
          tcc_pkg::ACT_TOGGLE: out_next = !out_reg;
          tcc_pkg::ACT_CLEAR:  out_next = 1'b0;
          tcc_pkg::ACT_SET:    out_next = 1'b1;
        endcase
      end else if (pwm && (act == tcc_pkg::ACT_CLEAR || act == tcc_pkg::ACT_SET)) begin
        if (match_ok) begin
          out_next = (act == tcc_pkg::ACT_CLEAR) ? level : !level;
        end
        if (fast && ceiling_match) begin
          out_next = (act == tcc_pkg::ACT_CLEAR);
        end
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ocr_live[i] <= tcc_pkg::RST_WORD;
        ocr_buf[i]  <= tcc_pkg::RST_WORD;
        flag_reg    <= tcc_pkg::RST_BIT;
        out_reg     <= tcc_pkg::RST_BIT;
      end else begin
        ocr_live[i] <= live_next;
        ocr_buf[i]  <= buf_next;
        flag_reg    <= flag_next;
        out_reg     <= out_next;
      end
    end

    assign ch_stat[i].flag      = flag_reg;
    assign ch_stat[i].irq       = flag_reg && ch_ctrl[i].irq_enable;
    assign ch_stat[i].out_state = out_reg;
  end

  property p_cap_load;
    @(posedge clk) disable iff (rst)
      cap_take |=> (capture_value_reg == $past(counter_value)) && capture_flag;
  endproperty
  a_cap_load: assert property (p_cap_load) else $error("capture did not load counter");

  property p_cap_off;
    @(posedge clk) disable iff (rst)
      (cap_is_top(waveform_mode_sel)
       && !(cpu_req.wr && cpu_req.sel == tcc_pkg::SEL_CAP_LO))
        |=> $stable(capture_value_reg) && !$rose(capture_flag);
  endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture in ceiling mode");

  property p_cmp_flag;
    @(posedge clk) disable iff (rst)
      (timer_tick && !block_reg && counter_value == ocr_live[0]) |=> ch_stat[0].flag;
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set");

  property p_cnt_block;
    @(posedge clk) disable iff (rst)
      (block_reg && timer_tick && !ch_stat[1].flag) |=> !ch_stat[1].flag;
  endproperty
  a_cnt_block: assert property (p_cnt_block) else $error("match after counter write");

  property p_live_write;
    @(posedge clk) disable iff (rst)
      (cpu_req.wr && cpu_req.sel == tcc_pkg::SEL_CMP_B_LO && !pwm)
        |=> ocr_live[1] == {$past(temp_reg), $past(cpu_req.wdata)};
  endproperty
  a_live_write: assert property (p_live_write) else $error("direct compare write lost");

  property p_buf_write;
    @(posedge clk) disable iff (rst)
      (cpu_req.wr && cpu_req.sel == tcc_pkg::SEL_CMP_A_LO && pwm)
        |=> ocr_buf[0] == {$past(temp_reg), $past(cpu_req.wdata)};
  endproperty
  a_buf_write: assert property (p_buf_write) else $error("buffered compare write lost");

  property p_force;
    @(posedge clk) disable iff (rst)
      (ch_ctrl[2].force_strobe && !pwm && ch_ctrl[2].action == tcc_pkg::ACT_SET
       && !timer_tick && !ch_stat[2].flag) |=> ch_stat[2].out_state && !ch_stat[2].flag;
  endproperty
  a_force: assert property (p_force) else $error("force strobe misbehaved");

  property p_act_none;
    @(posedge clk) disable iff (rst)
      (ch_ctrl[0].action == tcc_pkg::ACT_NONE) |=> $stable(ch_stat[0].out_state);
  endproperty
  a_act_none: assert property (p_act_none) else $error("output moved with no action");

  property p_flag_clr;
    @(posedge clk) disable iff (rst)
      (ch_ctrl[0].flag_clear && !timer_tick) |=> !ch_stat[0].flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("compare flag not cleared");

endmodule // tcc_capture_compare

// ### rtl/tcc_pkg.sv
// Shared constants, encodings and carrier types of the timer capture/compare unit
package tcc_pkg;

  localparam int          CH_NUM     = 3;
  localparam int          NC_SAMPLES = 4;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic        RST_BIT    = 1'b0;

  // Waveform generation modes
  typedef enum logic [3:0] {
    WGM_NORMAL   = 4'h0,
    WGM_PC8      = 4'h1,
    WGM_PC9      = 4'h2,
    WGM_PC10     = 4'h3,
    WGM_CTC_CMP  = 4'h4,
    WGM_FAST8    = 4'h5,
    WGM_FAST9    = 4'h6,
    WGM_FAST10   = 4'h7,
    WGM_PFC_CAP  = 4'h8,
    WGM_PFC_CMP  = 4'h9,
    WGM_PC_CAP   = 4'ha,
    WGM_PC_CMP   = 4'hb,
    WGM_CTC_CAP  = 4'hc,
    WGM_RESERVED = 4'hd,
    WGM_FAST_CAP = 4'he,
    WGM_FAST_CMP = 4'hf
  } tcc_wgm_t;

  // Byte locations reachable by the CPU; bits [2:1] pick the channel, bit 0 the high byte
  typedef enum logic [2:0] {
    SEL_CMP_A_LO = 3'h0,
    SEL_CMP_A_HI = 3'h1,
    SEL_CMP_B_LO = 3'h2,
    SEL_CMP_B_HI = 3'h3,
    SEL_CMP_C_LO = 3'h4,
    SEL_CMP_C_HI = 3'h5,
    SEL_CAP_LO   = 3'h6,
    SEL_CAP_HI   = 3'h7
  } tcc_sel_t;

  localparam logic [1:0] SEL_CHAN_CAP = 2'h3;

  // Compare output actions
  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR  = 2'h2,
    ACT_SET    = 2'h3
  } tcc_act_t;

  typedef struct packed {
    logic     wr;
    logic     rd;
    tcc_sel_t sel;
    logic [7:0] wdata;
  } tcc_cpu_req_t;

  typedef struct packed {
    tcc_act_t action;
    logic     irq_enable;
    logic     force_strobe;
    logic     flag_clear;
    logic     irq_ack;
  } tcc_ch_ctrl_t;

  typedef struct packed {
    logic flag;
    logic irq;
    logic out_state;
  } tcc_ch_stat_t;

endpackage

// ### rtl/tcc_capture_filter.sv
// Capture input synchroniser, four-sample noise canceler and edge detector
module tcc_capture_filter (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Selected raw trigger and its controls
  input  wire logic raw_in,
  input  wire logic cancel_en,
  input  wire logic detect_en,
  input  wire logic edge_rising,
  // Qualified capture event
  output logic      cap_event
);

  logic                                sync1_reg;
  logic                                sync2_reg;
  logic [tcc_pkg::NC_SAMPLES-1:0]      hist_reg;
  logic [tcc_pkg::NC_SAMPLES-1:0]      hist_next;
  logic                                filt_reg;
  logic                                filt_next;
  logic                                prev_reg;
  logic                                prev_next;

  always_comb begin
    hist_next = {hist_reg[tcc_pkg::NC_SAMPLES-2:0], sync2_reg};
    prev_next = filt_reg;
    filt_next = filt_reg;
    if (!cancel_en) begin
      filt_next = sync2_reg;
    end else if (&hist_reg) begin
      filt_next = 1'b1;
    end else if (~|hist_reg) begin
      filt_next = 1'b0;
    end
  end

  // Samples on every system clock, prescaler plays no part
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= tcc_pkg::RST_BIT;
      sync2_reg <= tcc_pkg::RST_BIT;
      hist_reg  <= '0;
      filt_reg  <= tcc_pkg::RST_BIT;
      prev_reg  <= tcc_pkg::RST_BIT;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      hist_reg  <= hist_next;
      filt_reg  <= filt_next;
      prev_reg  <= prev_next;
    end
  end

  // Edge detector works on the filtered level
  assign cap_event = detect_en && (filt_reg != prev_reg)
                     && (filt_reg == edge_rising);

  property p_nc_agree;
    @(posedge clk) disable iff (rst)
      ($past(cancel_en) && $changed(filt_reg)) |->
        ($past(hist_reg) == {tcc_pkg::NC_SAMPLES{filt_reg}});
  endproperty
  a_nc_agree: assert property (p_nc_agree) else $error("filter changed without agreement");

endmodule // tcc_capture_filter

// ### dv/tcc_cpu_model.sv
// Behavioural CPU issuing byte accesses on the timer's I/O data bus
module tcc_cpu_model (
  // Clock
  input  wire logic             clk,
  // Byte bus
  input  wire logic [7:0]       cpu_rdata,
  output tcc_pkg::tcc_cpu_req_t cpu_req
);
  timeunit 1ns;
  timeprecision 100ps;

  initial cpu_req = '0;

  // High byte goes to the holding byte, the low-byte write commits all 16 bits
  task automatic wr16(input logic [1:0] chan, input logic [15:0] val);
    @(posedge clk);
    #1;
    cpu_req = '{wr: 1'b1, rd: 1'b0, sel: tcc_pkg::tcc_sel_t'({chan, 1'b1}), wdata: val[15:8]};
    @(posedge clk);
    #1;
    cpu_req.sel   = tcc_pkg::tcc_sel_t'({chan, 1'b0});
    cpu_req.wdata = val[7:0];
    @(posedge clk);
    #1;
    cpu_req = '0;
  endtask

  task automatic rd8(input logic [2:0] sel, output logic [7:0] data);
    @(posedge clk);
    #1;
    cpu_req.rd  = 1'b1;
    cpu_req.sel = tcc_pkg::tcc_sel_t'(sel);
    @(posedge clk);
    #1;
    cpu_req = '0;
    data    = cpu_rdata;
  endtask
endmodule // tcc_cpu_model

// ### dv/tcc_capture_compare_bench.sv
// Self-checking bench for the timer capture/compare unit
module tcc_capture_compare_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LIMIT = 2000;

  typedef struct {
    logic [1:0]        ch;
    tcc_pkg::tcc_act_t act;
    logic [15:0]       val;
    logic              out;
  } tcc_row_t;

  // Match rows in normal mode: channel, action, compare value, output after match
  tcc_row_t rows [7] = '{
    '{2'h0, tcc_pkg::ACT_SET,    16'h1234, 1'b1},
    '{2'h0, tcc_pkg::ACT_NONE,   16'hffff, 1'b1},
    '{2'h0, tcc_pkg::ACT_TOGGLE, 16'h0001, 1'b0},
    '{2'h1, tcc_pkg::ACT_TOGGLE, 16'h0200, 1'b1},
    '{2'h1, tcc_pkg::ACT_CLEAR,  16'h8000, 1'b0},
    '{2'h2, tcc_pkg::ACT_SET,    16'habcd, 1'b1},
    '{2'h2, tcc_pkg::ACT_TOGGLE, 16'h0000, 1'b0}
  };

  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  timer_tick = 1'b0;
  logic [15:0]           counter_value = 16'h0000;
  logic                  counter_down = 1'b0;
  logic                  counter_write = 1'b0;
  logic [3:0]            waveform_mode_sel = 4'h0;
  logic                  capture_input_pin = 1'b0;
  logic                  comparator_output = 1'b0;
  logic                  comparator_capture_select = 1'b0;
  logic                  capture_noise_cancel_en = 1'b0;
  logic                  capture_edge_rising = 1'b1;
  logic                  capture_irq_enable = 1'b0;
  logic                  capture_flag_clear = 1'b0;
  logic                  capture_irq_ack = 1'b0;
  logic [15:0]           ceiling_value;
  logic                  ceiling_match;
  logic [15:0]           capture_value_reg;
  logic                  capture_flag;
  logic                  capture_irq;
  logic [7:0]            cpu_rdata;
  logic [7:0]            d;
  tcc_pkg::tcc_cpu_req_t cpu_req;
  tcc_pkg::tcc_ch_ctrl_t ch_ctrl [tcc_pkg::CH_NUM];
  tcc_pkg::tcc_ch_stat_t ch_stat [tcc_pkg::CH_NUM];
  int                    bad_count = 0;
  int                    checks_done = 0;
  int                    cycles = 0;
  int                    c;

  always #2.5 clk = ~clk;

  tcc_cpu_model cpu (.clk, .cpu_rdata, .cpu_req);

  tcc_capture_compare dut (
    .clk, .rst, .timer_tick, .counter_value, .counter_down, .counter_write,
    .waveform_mode_sel, .ceiling_value, .ceiling_match, .capture_input_pin,
    .comparator_output, .comparator_capture_select, .capture_noise_cancel_en,
    .capture_edge_rising, .capture_irq_enable, .capture_flag_clear, .capture_irq_ack,
    .capture_value_reg, .capture_flag, .capture_irq, .cpu_req, .cpu_rdata,
    .ch_ctrl, .ch_stat
  );

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, bad_count);
  endtask

  // One timer tick with the counter at v
  task automatic tick_at(input logic [15:0] v);
    step();
    counter_value = v;
    timer_tick    = 1'b1;
    step();
    timer_tick    = 1'b0;
  endtask

  initial begin
    ch_ctrl = '{default: '0};
    step(20);
    rst = 1'b0;
    foreach (rows[i]) begin
      c = rows[i].ch;
      cpu.wr16(rows[i].ch, rows[i].val);
      ch_ctrl[c].action     = rows[i].act;
      ch_ctrl[c].irq_enable = 1'b1;
      cpu.rd8({rows[i].ch, 1'b0}, d);
      chk_val({8'h00, d}, {8'h00, rows[i].val[7:0]});
      cpu.rd8({rows[i].ch, 1'b1}, d);
      chk_val({8'h00, d}, {8'h00, rows[i].val[15:8]});
      tick_at(rows[i].val);
      chk_bit(ch_stat[c].flag, 1'b1);
      chk_bit(ch_stat[c].irq, 1'b1);
      chk_bit(ch_stat[c].out_state, rows[i].out);
      ch_ctrl[c].irq_ack    = i[0];
      ch_ctrl[c].flag_clear = !i[0];
      step();
      ch_ctrl[c].irq_ack    = 1'b0;
      ch_ctrl[c].flag_clear = 1'b0;
      chk_bit(ch_stat[c].flag, 1'b0);
    end
    end_test("match rows");
    counter_value      = 16'h4321;
    capture_irq_enable = 1'b1;
    capture_input_pin  = 1'b1;
    step(3);
    chk_bit(capture_flag, 1'b0);
    step();
    chk_bit(capture_flag, 1'b1);
    chk_bit(capture_irq, 1'b1);
    chk_val(capture_value_reg, 16'h4321);
    cpu.rd8(3'h6, d);
    chk_val({8'h00, d}, 16'h0021);
    cpu.rd8(3'h7, d);
    chk_val({8'h00, d}, 16'h0043);
    capture_input_pin       = 1'b0;
    capture_noise_cancel_en = 1'b1;
    counter_value           = 16'h5a5a;
    step(12);
    capture_input_pin = 1'b1;
    step(7);
    chk_val(capture_value_reg, 16'h4321);
    step();
    chk_val(capture_value_reg, 16'h5a5a);
    capture_irq_ack = 1'b1;
    step();
    capture_irq_ack = 1'b0;
    chk_bit(capture_flag, 1'b0);
    capture_input_pin = 1'b0;
    step(12);
    capture_input_pin = 1'b1;
    step(3);
    capture_input_pin = 1'b0;
    step(12);
    chk_bit(capture_flag, 1'b0);
    capture_noise_cancel_en   = 1'b0;
    comparator_capture_select = 1'b1;
    step(6);
    capture_flag_clear = 1'b1;
    step();
    capture_flag_clear = 1'b0;
    comparator_output  = 1'b1;
    step(4);
    chk_bit(capture_flag, 1'b1);
    comparator_capture_select = 1'b0;
    waveform_mode_sel         = tcc_pkg::WGM_CTC_CAP;
    step(6);
    capture_flag_clear = 1'b1;
    step();
    capture_flag_clear = 1'b0;
    capture_input_pin  = 1'b1;
    step(10);
    chk_bit(capture_flag, 1'b0);
    end_test("capture");
    waveform_mode_sel = tcc_pkg::WGM_CTC_CMP;
    cpu.wr16(2'h0, 16'h0300);
    chk_val(ceiling_value, 16'h0300);
    waveform_mode_sel = tcc_pkg::WGM_FAST_CMP;
    counter_write     = 1'b1;
    step();
    counter_write = 1'b0;
    counter_value = 16'h0300;
    timer_tick    = 1'b1;
    #1;
    chk_bit(ceiling_match, 1'b0);
    step();
    timer_tick = 1'b0;
    chk_bit(ch_stat[0].flag, 1'b0);
    tick_at(16'h0300);
    chk_bit(ch_stat[0].flag, 1'b1);
    waveform_mode_sel = tcc_pkg::WGM_FAST8;
    cpu.wr16(2'h1, 16'h0010);
    cpu.rd8(3'h2, d);
    chk_val({8'h00, d}, 16'h0010);
    tick_at(16'h0010);
    chk_bit(ch_stat[1].flag, 1'b0);
    tick_at(16'h00ff);
    tick_at(16'h0010);
    chk_bit(ch_stat[1].flag, 1'b1);
    waveform_mode_sel = tcc_pkg::WGM_PC8;
    counter_down      = 1'b1;
    tick_at(16'h0010);
    chk_bit(ch_stat[1].out_state, 1'b1);
    counter_down = 1'b0;
    tick_at(16'h0010);
    chk_bit(ch_stat[1].out_state, 1'b0);
    end_test("buffering and blocking");
    waveform_mode_sel       = tcc_pkg::WGM_NORMAL;
    ch_ctrl[2].action       = tcc_pkg::ACT_SET;
    ch_ctrl[2].force_strobe = 1'b1;
    step();
    ch_ctrl[2].force_strobe = 1'b0;
    chk_bit(ch_stat[2].out_state, 1'b1);
    chk_bit(ch_stat[2].flag, 1'b0);
    waveform_mode_sel = tcc_pkg::WGM_PC8;
    step(2);
    chk_bit(ch_stat[2].out_state, 1'b1);
    end_test("force");
    waveform_mode_sel = tcc_pkg::WGM_PFC_CMP;
    cpu.wr16(2'h1, 16'h0020);
    tick_at(16'h0000);
    waveform_mode_sel = tcc_pkg::WGM_NORMAL;
    cpu.rd8(3'h2, d);
    chk_val({8'h00, d}, 16'h0020);
    capture_edge_rising = 1'b0;
    capture_flag_clear  = 1'b1;
    counter_value       = 16'h0777;
    step();
    capture_flag_clear = 1'b0;
    capture_input_pin  = 1'b0;
    step(3);
    chk_bit(capture_flag, 1'b0);
    step();
    chk_bit(capture_flag, 1'b1);
    chk_val(capture_value_reg, 16'h0777);
    end_test("floor load and falling capture");
    rst = 1'b1;
    #1;
    chk_val(capture_value_reg, 16'h0000);
    chk_bit(ch_stat[2].out_state, 1'b0);
    chk_bit(ch_stat[1].flag, 1'b0);
    step();
    rst = 1'b0;
    end_test("reset");
    finish_test();
  end
endmodule // tcc_capture_compare_bench
